// ===== rtl/gtc_timer_counters.sv
// General purpose timer, free-running count and dropped frame count.
// Assumes a register master on the core clock and same-clock drop pulses.
//
// Operation
// RULE1 - Run bit 29 written one starts the timer; written zero halts it.
// RULE2 - Run bit falling from one to zero forces the preload field to FFFFh.
// RULE3 - Preload field bits 15-0 give the value loaded into the timer.
// RULE4 - Running timer raises an interrupt at intervals set by the preload.
// RULE5 - Timer count register bits 15-0 read the present count, FFFFh after reset.
// RULE6 - Free-running 32-bit count starts at zero, steps each 25MHz cycle.
// RULE7 - Free-running count wraps to zero at its maximum and keeps going.
// RULE8 - In 16-bit mode the first half read latches the whole count.
// RULE9 - Free-running count may take up to 160ns to read cleared after reset.
// RULE10 - Free-running count keeps running in power states D0, D1 and D2.
// RULE11 - Dropped frame count bits 31-0 add one per discarded frame.
// RULE12 - Any read of the dropped frame count returns it and clears it.
// RULE13 - Dropped frame count stepping to 80000000h can raise an interrupt.
// RULE14 - Timer counts down from preload, reloads at zero and flags an event.
// RULE15 - Reserved bits read zero and ignore writes.
//
// The implementer's own choice: strobed register access.

`timescale 1ns/1ps
`default_nettype none

module gtc_timer_counters
  import gtc_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Register port
  input  wire gtc_bus_req_t busReq,
  output logic [DATA_W-1:0] rdData,
  // Receiver events
  input  wire logic         frameDropped,
  // Interrupt
  output logic              irq
);

  // Counter rate tick
  logic tick;

  // One tick every five core cycles gives the 25 MHz count rate
  gtc_tick_gen u_tick (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick     (tick)
  );

  // Access decode
  logic wrCfg;
  logic wrStat;
  logic wrMask;
  logic wrCtrl;
  logic rdFreeLo;
  logic rdFreeHi;
  logic rdFree;
  logic rdDrop;

  // Register state
  gtc_tmr_state_t  tmrState_ff;
  logic [15:0]     preload_ff;
  logic [15:0]     timerCount_ff;
  logic [31:0]     freeCount_ff;
  logic [31:0]     freeLatch_ff;
  logic            latchPend_ff;
  logic            halfMode_ff;
  logic [31:0]     dropCount_ff;
  gtc_irq_t        irqStat_ff;
  gtc_irq_t        irqMask_ff;
  logic            irq_ff;
  logic [31:0]     rdData_ff;

  // Next values and events
  gtc_tmr_state_t  nxt_tmrState;
  logic [15:0]     nxt_preload;
  logic [31:0]     nxt_rdData;
  logic [31:0]     freeSel;
  logic [31:0]     dropInc;
  logic            runWrite;
  logic            haltWrite;
  logic            startWrite;
  logic            timerZeroEvt;
  logic            dropHalfEvt;
  gtc_irq_t        irqEvt;
  gtc_irq_t        irqClr;

  // Offset decode of the one-cycle strobes
  assign wrCfg    = busReq.wrStb && (busReq.addr == OFS_TIMER_CFG);
  assign wrStat   = busReq.wrStb && (busReq.addr == OFS_IRQ_STATUS);
  assign wrMask   = busReq.wrStb && (busReq.addr == OFS_IRQ_MASK);
  assign wrCtrl   = busReq.wrStb && (busReq.addr == OFS_HOST_CTRL);
  assign rdFreeLo = busReq.rdStb && (busReq.addr == OFS_FREE_COUNT);
  assign rdFreeHi = busReq.rdStb && halfMode_ff && (busReq.addr == OFS_FREE_COUNT_HI);
  assign rdFree   = rdFreeLo || rdFreeHi;
  assign rdDrop   = busReq.rdStb && (busReq.addr == OFS_DROP_COUNT);

  // General purpose timer
  // Run state, preload field and the down counter on the rate tick

  // A run write while running only refreshes the preload
  assign runWrite   = wrCfg && busReq.wrData[CFG_RUN_BIT];
  assign haltWrite  = wrCfg && !busReq.wrData[CFG_RUN_BIT];
  // A run write to a halted timer starts it with the written preload
  assign startWrite = runWrite && (tmrState_ff == TMR_HALT);

  // Run state follows the written run bit
  always_comb begin
    nxt_tmrState = tmrState_ff;
    unique case (tmrState_ff)
      TMR_HALT: begin
        if (runWrite) begin
          nxt_tmrState = TMR_RUN; // see RULE1
        end
      end
      TMR_RUN: begin
        if (haltWrite) begin
          nxt_tmrState = TMR_HALT; // see RULE1
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tmrState_ff <= TMR_HALT;
    end else begin
      tmrState_ff <= nxt_tmrState;
    end
  end

  // Preload takes the written field unless the write halts a running timer
  always_comb begin
    nxt_preload = preload_ff;
    if (wrCfg) begin
      if ((tmrState_ff == TMR_RUN) && haltWrite) begin
        nxt_preload = PRELOAD_HALTED; // see RULE2
      end else begin
        nxt_preload = busReq.wrData[CFG_PRELOAD_MSB:CFG_PRELOAD_LSB]; // see RULE3
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      preload_ff <= PRELOAD_RST;
    end else begin
      preload_ff <= nxt_preload;
    end
  end

  // Zero seen on a tick: reload and flag, so one interval is preload + 1 ticks
  assign timerZeroEvt = (tmrState_ff == TMR_RUN) && tick && (timerCount_ff == 16'h0000);

  // Down counter; a fresh start loads the value being written
  // Halted, the count holds its last value
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timerCount_ff <= TIMER_CNT_RST; // see RULE5
    end else if (startWrite) begin
      timerCount_ff <= nxt_preload; // see RULE3
    end else if (tmrState_ff == TMR_RUN && tick) begin
      if (timerCount_ff == 16'h0000) begin
        timerCount_ff <= preload_ff; // see RULE14
      end else begin
        timerCount_ff <= timerCount_ff - 16'h0001; // see RULE14
      end
    end
  end

  // Free-running counter
  // Advances on every rate tick from reset onwards

  // Cleared in the first edge of reset, well inside the allowed settle time
  // No power state gates the count
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      freeCount_ff <= FREE_CNT_RST; // see RULE6 see RULE9
    end else if (tick) begin
      freeCount_ff <= freeCount_ff + 32'h0000_0001; // see RULE6 see RULE7 see RULE10
    end
  end

  // Host bus width: one selects half-word reads of the free count
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      halfMode_ff <= 1'b0;
    end else if (wrCtrl) begin
      halfMode_ff <= busReq.wrData[CTRL_HALF_BIT];
    end
  end

  // Snapshot of the whole count, taken by the first half read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      freeLatch_ff <= FREE_CNT_RST;
    end else if (halfMode_ff && rdFree && !latchPend_ff) begin
      freeLatch_ff <= freeCount_ff; // see RULE8
    end
  end

  // Pairing flag: set by the first half read, released by the second
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      latchPend_ff <= 1'b0;
    end else if (!halfMode_ff) begin
      latchPend_ff <= 1'b0;
    end else if (rdFree) begin
      latchPend_ff <= !latchPend_ff; // see RULE8
    end
  end

  // The second read of a pair sees the snapshot, any other read the live count
  assign freeSel = latchPend_ff ? freeLatch_ff : freeCount_ff;

  // Dropped frame counter
  // Counts discarded frames, cleared by any read of its register

  // Midpoint event is the step from 7FFFFFFFh; a read-clear in the same cycle wins
  assign dropInc     = dropCount_ff + 32'h0000_0001;
  assign dropHalfEvt = frameDropped && !rdDrop && (dropInc == DROP_MIDPOINT);

  // A drop in the read cycle counts into the cleared value
  // Wraps past FFFFFFFFh like any binary counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dropCount_ff <= DROP_CNT_RST;
    end else if (rdDrop) begin
      dropCount_ff <= frameDropped ? 32'h0000_0001 : DROP_CNT_RST; // see RULE12
    end else if (frameDropped) begin
      dropCount_ff <= dropInc; // see RULE11
    end
  end

  // Interrupt status and mask
  // Sticky status per source, a mask of the same layout, one level output

  // This cycle's events and write-one-to-clear requests
  always_comb begin
    irqEvt           = '0;
    irqEvt.timerZero = timerZeroEvt; // see RULE4 see RULE14
    irqEvt.dropHalf  = dropHalfEvt;  // see RULE13
    irqClr           = '0;
    if (wrStat) begin
      irqClr.timerZero = busReq.wrData[IRQ_TIMER_BIT];
      irqClr.dropHalf  = busReq.wrData[IRQ_DROP_BIT];
    end
  end

  // New event wins over a clear in the same cycle
  // Status bits stay set until written with one
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqStat_ff <= '0;
    end else begin
      irqStat_ff <= gtc_irq_t'((irqStat_ff & ~irqClr) | irqEvt);
    end
  end

  // Mask bits share the status layout
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqMask_ff <= '0;
    end else if (wrMask) begin
      irqMask_ff.timerZero <= busReq.wrData[IRQ_TIMER_BIT];
      irqMask_ff.dropHalf  <= busReq.wrData[IRQ_DROP_BIT];
    end
  end

  // Level output from a flop, one cycle behind status and mask
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irqStat_ff & irqMask_ff); // see RULE4 see RULE13
    end
  end

  // Read path
  // Answer formed in the strobe cycle, registered for the next

  // Unused bits and unmapped offsets return zero
  always_comb begin
    nxt_rdData = RD_ZERO; // see RULE15
    if (busReq.rdStb) begin
      unique case (busReq.addr)
        OFS_TIMER_CFG: begin
          nxt_rdData[CFG_RUN_BIT] = (tmrState_ff == TMR_RUN); // see RULE1
          nxt_rdData[CFG_PRELOAD_MSB:CFG_PRELOAD_LSB] = preload_ff;
        end
        OFS_TIMER_COUNT: begin
          nxt_rdData[15:0] = timerCount_ff; // see RULE5
        end
        OFS_FREE_COUNT: begin
          // Half mode answers in the low half-word
          if (halfMode_ff) begin
            nxt_rdData[15:0] = freeSel[15:0]; // see RULE8
          end else begin
            nxt_rdData = freeCount_ff;
          end
        end
        OFS_FREE_COUNT_HI: begin
          if (halfMode_ff) begin
            nxt_rdData[15:0] = freeSel[31:16]; // see RULE8
          end
        end
        OFS_DROP_COUNT: begin
          nxt_rdData = dropCount_ff; // see RULE12
        end
        OFS_IRQ_STATUS: begin
          nxt_rdData[IRQ_TIMER_BIT] = irqStat_ff.timerZero;
          nxt_rdData[IRQ_DROP_BIT]  = irqStat_ff.dropHalf;
        end
        OFS_IRQ_MASK: begin
          nxt_rdData[IRQ_TIMER_BIT] = irqMask_ff.timerZero;
          nxt_rdData[IRQ_DROP_BIT]  = irqMask_ff.dropHalf;
        end
        OFS_HOST_CTRL: begin
          nxt_rdData[CTRL_HALF_BIT] = halfMode_ff;
        end
        default: begin
          nxt_rdData = RD_ZERO;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdData_ff <= RD_ZERO;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // Top outputs straight from flops
  assign rdData = rdData_ff;
  assign irq    = irq_ff;

endmodule

`default_nettype wire

// ===== rtl/gtc_pkg.sv
// Shared constants and types of the timer and statistics counter block.
// Assumes a single 125 MHz core clock and a plain register port.

package gtc_pkg;

  // Clocking
  localparam int unsigned CLK_FREQ_HZ  = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned FR_FREQ_HZ   = 25_000_000;
  localparam int unsigned FR_DIV       = CLK_FREQ_HZ / FR_FREQ_HZ;
  localparam int unsigned TICK_W       = 3;
  localparam int unsigned FR_CLEAR_NS  = 160;
  localparam int unsigned FR_CLEAR_CYC = FR_CLEAR_NS / CLK_PERIOD_NS;

  // Register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets
  localparam logic [7:0] OFS_TIMER_CFG     = 8'h8C;
  localparam logic [7:0] OFS_TIMER_COUNT   = 8'h90;
  localparam logic [7:0] OFS_FREE_COUNT    = 8'h9C;
  localparam logic [7:0] OFS_FREE_COUNT_HI = 8'h9E;
  localparam logic [7:0] OFS_DROP_COUNT    = 8'hA0;
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'hB0;
  localparam logic [7:0] OFS_IRQ_MASK      = 8'hB4;
  localparam logic [7:0] OFS_HOST_CTRL     = 8'hB8;

  // Field positions
  localparam int unsigned CFG_RUN_BIT      = 29;
  localparam int unsigned CFG_PRELOAD_LSB  = 0;
  localparam int unsigned CFG_PRELOAD_MSB  = 15;
  localparam int unsigned CTRL_HALF_BIT    = 0;
  localparam int unsigned IRQ_TIMER_BIT    = 0;
  localparam int unsigned IRQ_DROP_BIT     = 1;
  localparam int unsigned HALF_SEL_BIT     = 1;

  // Reset and forced values
  localparam logic [15:0] PRELOAD_RST    = 16'hFFFF;
  localparam logic [15:0] PRELOAD_HALTED = 16'hFFFF;
  localparam logic [15:0] TIMER_CNT_RST  = 16'hFFFF;
  localparam logic [31:0] FREE_CNT_RST   = 32'h0000_0000;
  localparam logic [31:0] DROP_CNT_RST   = 32'h0000_0000;
  localparam logic [31:0] DROP_MIDPOINT  = 32'h8000_0000;
  localparam logic [31:0] RD_ZERO        = 32'h0000_0000;

  // Register port request
  typedef struct packed {
    logic              wrStb;
    logic              rdStb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } gtc_bus_req_t;

  // Sticky interrupt sources, high bit first
  typedef struct packed {
    logic dropHalf;
    logic timerZero;
  } gtc_irq_t;

  // Timer run state
  typedef enum logic [0:0] {
    TMR_HALT = 1'b0,
    TMR_RUN  = 1'b1
  } gtc_tmr_state_t;

endpackage

// ===== rtl/gtc_tick_gen.sv
// Divider that gives a one-cycle tick at the counter rate.
// Assumes the core clock and a synchronous active-high reset.

`timescale 1ns/1ps
`default_nettype none

module gtc_tick_gen
  import gtc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Tick out
  output logic      tick
);

  localparam logic [TICK_W-1:0] DIV_LAST = TICK_W'(FR_DIV - 1);

  logic [TICK_W-1:0] divCnt_ff;
  logic              tick_ff;

  // Restarts from reset so the first tick is a fixed time after release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      divCnt_ff <= '0;
      tick_ff   <= 1'b0;
    end else if (divCnt_ff == DIV_LAST) begin
      divCnt_ff <= '0;
      tick_ff   <= 1'b1;
    end else begin
      divCnt_ff <= divCnt_ff + TICK_W'(1);
      tick_ff   <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule

`default_nettype wire

// ===== verif/gtc_timer_monitor.sv
// Port checker of the timer and counter block.
// Assumes binding to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_monitor
  import gtc_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              sys_rst,
  // Watched ports
  input wire gtc_bus_req_t      busReq,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic              frameDropped,
  input wire logic              irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic rdCfg, rdCnt, rdDrop, rdFree, wrCfg;
  assign rdCfg  = busReq.rdStb && busReq.addr == OFS_TIMER_CFG;
  assign rdCnt  = busReq.rdStb && busReq.addr == OFS_TIMER_COUNT;
  assign rdDrop = busReq.rdStb && busReq.addr == OFS_DROP_COUNT;
  assign rdFree = busReq.rdStb && busReq.addr == OFS_FREE_COUNT;
  assign wrCfg  = busReq.wrStb && busReq.addr == OFS_TIMER_CFG;
  a_rd_idle_zero: assert property (
    !$past(busReq.rdStb) |-> rdData == RD_ZERO) else $error("read data outside answer");
  a_cfg_rsvd_zero: assert property (
    $past(rdCfg) |-> rdData[31:30] == 2'h0 && rdData[28:16] == 13'h0)
    else $error("config reserved bits set");
  a_cnt_rsvd_zero: assert property (
    $past(rdCnt) |-> rdData[31:16] == 16'h0) else $error("count upper half set");
  a_drop_clear: assert property (
    rdDrop && !frameDropped ##1 rdDrop |=> rdData == DROP_CNT_RST)
    else $error("drop count not cleared by read");
  a_drop_one: assert property (
    rdDrop && frameDropped ##1 rdDrop |=> rdData == 32'h1)
    else $error("drop in read cycle lost");
  a_mask_quiet: assert property (
    busReq.wrStb && busReq.addr == OFS_IRQ_MASK && busReq.wrData[1:0] == 2'h0
    |-> ##2 !irq) else $error("interrupt with all masked");
  a_halt_preload: assert property (
    wrCfg && busReq.wrData[29] ##1 wrCfg && !busReq.wrData[29] ##1 rdCfg
    |=> rdData == {16'h0, PRELOAD_HALTED}) else $error("halt did not force preload");
  a_free_step: assert property (
    rdFree ##1 rdFree |=> (rdData - $past(rdData)) <= 32'h1)
    else $error("free count jumped");
endmodule
bind gtc_timer_counters gtc_timer_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
  .busReq(busReq), .rdData(rdData), .frameDropped(frameDropped), .irq(irq));
`default_nettype wire

// ===== verif/gtc_drop_source.sv
// Receiver model that discards frames on request.
// Assumes the core clock; one pulse per frame with a gap cycle.
`timescale 1ns/1ps
`default_nettype none
module gtc_drop_source
  import gtc_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // Burst request
  input wire logic       go,
  input wire logic [7:0] burst,
  // Drop event
  output logic           frameDropped
);
  logic [7:0] pend_ff;
  logic       fire;
  assign fire = pend_ff != 8'h00 && !frameDropped;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_ff      <= 8'h00;
      frameDropped <= 1'h0;
    end else begin
      frameDropped <= fire;
      pend_ff      <= pend_ff - {7'h0, fire} + (go ? burst : 8'h00);
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_gp_timer_and_counters.sv
// Self-checking bench of the timer and counter block.
// Assumes the drop source model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module test_gp_timer_and_counters
  import gtc_pkg::*;
;
  logic              core_clk = 1'h0;
  logic              sys_rst  = 1'h1;
  gtc_bus_req_t      busReq   = '0;
  logic [DATA_W-1:0] rdData;
  logic              frameDropped;
  logic              irq;
  logic              go       = 1'h0;
  logic [7:0]        burst    = 8'h00;
  logic [31:0]       v, w, q;
  int                badCount   = 0;
  int                checkCount = 0;
  int                cycCount   = 0;

  gtc_timer_counters DUT (.core_clk(core_clk), .sys_rst(sys_rst), .busReq(busReq),
    .rdData(rdData), .frameDropped(frameDropped), .irq(irq));
  gtc_drop_source u_src (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .burst(burst),
    .frameDropped(frameDropped));

  initial forever #4 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) begin
    cycCount++;
    if (cycCount == 5000) begin
      badCount++;
      printVerdict();
    end
  end

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic wr, input logic rd, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    busReq <= '{wrStb: wr, rdStb: rd, addr: a, wrData: d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    put(1'h1, 1'h0, a, d);
    put(1'h0, 1'h0, a, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    put(1'h0, 1'h1, a, 32'h0);
    put(1'h0, 1'h0, a, 32'h0);
    #1 r = rdData;
  endtask
  task automatic chkRd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    check(r, e);
  endtask
  // Two reads with no gap
  task automatic rd2(input logic [7:0] a, output logic [31:0] r1, output logic [31:0] r2);
    put(1'h0, 1'h1, a, 32'h0);
    put(1'h0, 1'h1, a, 32'h0);
    #1 r1 = rdData;
    put(1'h0, 1'h0, a, 32'h0);
    #1 r2 = rdData;
  endtask
  task automatic drops(input logic [7:0] n);
    @(posedge core_clk);
    burst <= n;
    go    <= 1'h1;
    @(posedge core_clk);
    go    <= 1'h0;
  endtask

  task automatic t_reset();
    chkRd(OFS_FREE_COUNT, FREE_CNT_RST);
    chkRd(OFS_TIMER_CFG, {16'h0, PRELOAD_RST});
    chkRd(OFS_TIMER_COUNT, {16'h0, TIMER_CNT_RST});
    chkRd(OFS_DROP_COUNT, DROP_CNT_RST);
    chkRd(OFS_FREE_COUNT_HI, RD_ZERO);
    chkRd(8'h40, RD_ZERO);
    chkRd(OFS_IRQ_STATUS, RD_ZERO);
  endtask
  task automatic t_access();
    wr(OFS_TIMER_CFG, 32'hDFFF_0005);
    chkRd(OFS_TIMER_CFG, 32'h0000_0005);
    wr(OFS_TIMER_COUNT, 32'h0000_1234);
    chkRd(OFS_TIMER_COUNT, {16'h0, TIMER_CNT_RST});
    wr(OFS_IRQ_MASK, 32'hFFFF_FFFF);
    chkRd(OFS_IRQ_MASK, 32'h0000_0003);
    wr(OFS_IRQ_MASK, 32'h0);
  endtask
  task automatic t_timer();
    wr(OFS_TIMER_CFG, 32'h2000_0003);
    rd(OFS_TIMER_COUNT, v);
    check({2'h0, v[31:2]}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (30) @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h0);
    chkRd(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h1);
    put(1'h1, 1'h0, OFS_TIMER_CFG, 32'h2000_0003);
    put(1'h1, 1'h0, OFS_TIMER_CFG, 32'h0000_1234);
    put(1'h0, 1'h1, OFS_TIMER_CFG, 32'h0);
    put(1'h0, 1'h0, OFS_TIMER_CFG, 32'h0);
    #1 check(rdData, {16'h0, PRELOAD_HALTED});
    rd(OFS_TIMER_COUNT, v);
    repeat (20) @(posedge core_clk);
    chkRd(OFS_TIMER_COUNT, v);
    wr(OFS_IRQ_STATUS, 32'hFFFF_FFFF);
    @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h0);
    chkRd(OFS_IRQ_STATUS, RD_ZERO);
  endtask
  task automatic t_drop();
    drops(8'h03);
    repeat (8) @(posedge core_clk);
    chkRd(OFS_DROP_COUNT, 32'h3);
    chkRd(OFS_DROP_COUNT, DROP_CNT_RST);
    drops(8'h01);
    rd2(OFS_DROP_COUNT, v, w);
    check(v, DROP_CNT_RST);
    check(w, 32'h1);
    rd2(OFS_DROP_COUNT, v, w);
    check(v, DROP_CNT_RST);
    check(w, DROP_CNT_RST);
  endtask
  task automatic t_free();
    rd(OFS_FREE_COUNT, v);
    repeat (48) @(posedge core_clk);
    rd(OFS_FREE_COUNT, w);
    check(w - v, 32'hA);
    rd2(OFS_FREE_COUNT, v, w);
    check({31'h0, (w - v) > 32'h1}, 32'h0);
    wr(OFS_HOST_CTRL, 32'h1);
    rd(OFS_FREE_COUNT_HI, v);
    repeat (48) @(posedge core_clk);
    rd(OFS_FREE_COUNT, w);
    wr(OFS_HOST_CTRL, 32'h0);
    repeat (6) @(posedge core_clk);
    rd(OFS_FREE_COUNT, q);
    check(q - 32'hC, {v[15:0], w[15:0]});
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    t_reset();
    t_access();
    t_timer();
    t_drop();
    t_free();
    printVerdict();
  end
endmodule
`default_nettype wire
